// ### pkg/flash_space_regs.vh
// flash space decoder constants: windows, offsets, region bounds, timing
// Function
// - tristate enable floats all outputs except scan outs
// - boundary scan on digital pins, listed exceptions
// - paired controllers drive half, two pixels, native
// - three selects, sixteen megabytes each, 48 total
// - firmware fetched through boot select at power-up
// - probe each select; no boot select, no boot
// - single flash up to 128 megabytes, eight blocks
// - windows f9, fa, f8 map to blocks 0-2
// - blocks 3-7 addressed identically, patterns only
// - application from f9020000, patterns from f9240000
// - 128 kilobyte bootloader at f9000000, must be intact
// - pre-stored mode copies images at sequence start
// - video-pattern mode loads images from video input
// - three extended address pins used only for address
// - never address beyond 128 megabytes
`ifndef FLASH_SPACE_REGS_VH
`define FLASH_SPACE_REGS_VH
`define WIN_CS2_TOP 8'hf8
`define WIN_CS0_TOP 8'hf9
`define WIN_CS1_TOP 8'hfa
`define BOOT_BASE 32'hf9000000
`define APP_BASE 32'hf9020000
`define RSV_BASE 32'hf9140000
`define RSV_LAST 32'hf923ffff
`define PAT_BASE 32'hf9240000
`define LIN_BLK_FIRST 3'h3
`define LIN_BLK_LAST 3'h7
`define BLK_CS0 3'h0
`define BLK_CS1 3'h1
`define BLK_CS2 3'h2
`define MODE_VIDEO 2'h0
`define MODE_VIDPAT 2'h1
`define MODE_PRESTORED 2'h2
`define MODE_OTF 2'h3
`define ACC_CYC_NS 100
`define ACC_CYC ((`ACC_CYC_NS + 3) / 4)
`define PROBE_WORD 16'hffff
`endif

// ### rtl/flash_addr_map.v
// combinational map of processor address onto flash selects and offset
`timescale 1ns/1ps
module flash_addr_map (
   // processor side
   input wire [31:0] cpu_addr,
   input wire linear_mode,
   // decoded result
   output reg hit,
   output reg [2:0] sel_onehot,
   output reg [26:0] flash_off,
   output reg rsv_hit
);
`include "flash_space_regs.vh"
   always @* begin
      hit = 1'b0;
      sel_onehot = 3'h0;
      flash_off = 27'h0;
      rsv_hit = (cpu_addr >= `RSV_BASE) && (cpu_addr <= `RSV_LAST);
      if (cpu_addr[31:24] == `WIN_CS0_TOP) begin
         hit = 1'b1;
         sel_onehot = 3'b001;
         flash_off = {`BLK_CS0, cpu_addr[23:0]};
      end else if (cpu_addr[31:24] == `WIN_CS1_TOP) begin
         hit = 1'b1;
         sel_onehot = 3'b010;
         flash_off = {`BLK_CS1, cpu_addr[23:0]};
      end else if (cpu_addr[31:24] == `WIN_CS2_TOP) begin
         hit = 1'b1;
         sel_onehot = 3'b100;
         flash_off = {`BLK_CS2, cpu_addr[23:0]};
      end else if (linear_mode && cpu_addr[31:27] == 5'h00 &&
                   cpu_addr[26:24] >= `LIN_BLK_FIRST) begin
         // identity map; bit 27 and above zero keeps us inside 128 MB
         hit = 1'b1;
         sel_onehot = 3'b111;
         flash_off = cpu_addr[26:0];
      end
   end
endmodule

// ### rtl/flash_space_decoder.v
// flash space decoder: chip selects, extended address, boot probe, test
`timescale 1ns/1ps
module flash_space_decoder (
   // clock and reset
   input wire mclk,
   input wire resetn,
   // configuration
   input wire linear_mode,
   input wire [1:0] op_mode,
   // processor access
   input wire acc_req,
   input wire acc_write,
   input wire [31:0] acc_addr,
   input wire [15:0] acc_wdata,
   output wire acc_ready,
   output reg [15:0] acc_rdata_r,
   output reg acc_err_r,
   // sequence and boot
   input wire seq_start,
   output reg preload_flash_r,
   output reg preload_video_r,
   output reg [2:0] present_r,
   output reg boot_done_r,
   output reg boot_fail_r,
   // flash bus
   output wire [23:0] flash_addr,
   output wire flash_select_zero,
   output wire flash_select_boot,
   output wire flash_select_two,
   output wire flash_ext_addr_a,
   output wire flash_ext_addr_b,
   output wire flash_ext_addr_c,
   output wire flash_oe_n,
   output wire flash_we_n,
   input wire [15:0] flash_data_in,
   output wire [15:0] flash_data_out,
   output wire flash_data_oe,
   output wire flash_pins_oe,
   // board test
   input wire in_circuit_tristate_enable,
   output wire scan_outs_oe
);
`include "flash_space_regs.vh"
   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam S_PROBE = 4'b0001;
   localparam S_IDLE = 4'b0010;
   localparam S_ACC = 4'b0100;
   localparam S_DEAD = 4'b1000;
   // the count is an integer expression; keep only the counter's width
   localparam integer ACC_N_FULL = `ACC_CYC;
   localparam [7:0] ACC_N = ACC_N_FULL[7:0];
   reg [3:0] state_r;
   reg [7:0] cnt_r;
   reg [1:0] probe_idx_r;
   reg [2:0] sel_r;
   reg [26:0] off_r;
   reg we_r;
   reg [15:0] wd_r;
   reg [2:0] tst_sync_r;
   reg tst_r;
   wire hit;
   wire [2:0] sel_oh;
   wire [26:0] off;
   wire rsv_hit;
   flash_addr_map u_map (
      .cpu_addr(acc_addr),
      .linear_mode(linear_mode),
      .hit(hit),
      .sel_onehot(sel_oh),
      .flash_off(off),
      .rsv_hit(rsv_hit)
   );
   // chip selects in linear mode derive from the block number
   function [2:0] blk_sel;
      input lin;
      input [2:0] sel;
      input [26:0] o;
      begin
         if (!lin) begin
            blk_sel = sel;
         end else if (o[26:24] == `BLK_CS1) begin
            blk_sel = 3'b010;
         end else if (o[26:24] == `BLK_CS2) begin
            blk_sel = 3'b100;
         end else begin
            blk_sel = 3'b001;
         end
      end
   endfunction
   // ------------------------------------------------------------
   // test pin sync (three stages, second and third agree)
   // ------------------------------------------------------------
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tst_sync_r <= 3'h0;
         tst_r <= 1'b0;
      end else begin
         tst_sync_r <= {tst_sync_r[1:0], in_circuit_tristate_enable};
         if (tst_sync_r[2] == tst_sync_r[1]) begin
            tst_r <= tst_sync_r[2];
         end
      end
   end
   // ------------------------------------------------------------
   // main sequencer
   // ------------------------------------------------------------
   wire acc_take = (state_r == S_IDLE) && acc_req;
   // writes into bootloader or reserved space would brick the part
   wire wr_block = acc_write && (rsv_hit || (acc_addr >= `BOOT_BASE &&
                   acc_addr < `APP_BASE));
   assign acc_ready = (state_r == S_IDLE);
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_r <= S_PROBE;
         cnt_r <= 8'h0;
         probe_idx_r <= 2'h1; // boot select probed first
         sel_r <= 3'h0;
         off_r <= 27'h0;
         we_r <= 1'b0;
         wd_r <= 16'h0;
         acc_rdata_r <= 16'h0;
         acc_err_r <= 1'b0;
         present_r <= 3'h0;
         boot_done_r <= 1'b0;
         boot_fail_r <= 1'b0;
         preload_flash_r <= 1'b0;
         preload_video_r <= 1'b0;
      end else begin
         acc_err_r <= 1'b0;
         preload_flash_r <= seq_start && boot_done_r &&
                            op_mode == `MODE_PRESTORED;
         preload_video_r <= seq_start && boot_done_r &&
                            op_mode == `MODE_VIDPAT;
         case (state_r)
            S_PROBE: begin
               sel_r <= (3'b001 << probe_idx_r);
               off_r <= 27'h0;
               we_r <= 1'b0;
               if (cnt_r == ACC_N) begin
                  cnt_r <= 8'h0;
                  sel_r <= 3'h0;
                  // floating bus reads all ones: nothing fitted
                  present_r[probe_idx_r] <= (flash_data_in != `PROBE_WORD);
                  if (probe_idx_r == 2'h1) begin
                     probe_idx_r <= 2'h0;
                  end else if (probe_idx_r == 2'h0) begin
                     probe_idx_r <= 2'h2;
                  end else if (!present_r[1]) begin
                     // every select is probed before the boot verdict
                     boot_fail_r <= 1'b1;
                     state_r <= S_DEAD;
                  end else begin
                     boot_done_r <= 1'b1;
                     state_r <= S_IDLE;
                  end
               end else begin
                  cnt_r <= cnt_r + 8'h1;
               end
            end
            S_IDLE: begin
               if (acc_take) begin
                  if (!hit || wr_block) begin
                     acc_err_r <= 1'b1;
                  end else begin
                     sel_r <= blk_sel(linear_mode, sel_oh, off);
                     off_r <= off;
                     we_r <= acc_write;
                     wd_r <= acc_wdata;
                     cnt_r <= 8'h0;
                     state_r <= S_ACC;
                  end
               end
            end
            S_ACC: begin
               if (cnt_r == ACC_N) begin
                  acc_rdata_r <= we_r ? acc_rdata_r : flash_data_in;
                  sel_r <= 3'h0;
                  we_r <= 1'b0;
                  cnt_r <= 8'h0;
                  state_r <= S_IDLE;
               end else begin
                  cnt_r <= cnt_r + 8'h1;
               end
            end
            S_DEAD: begin
               sel_r <= 3'h0;
            end
            default: begin
               state_r <= S_PROBE;
            end
         endcase
      end
   end
   // ------------------------------------------------------------
   // flash pins
   // ------------------------------------------------------------
   wire bus_act = (sel_r != 3'h0);
   assign flash_select_zero = ~sel_r[0];
   assign flash_select_boot = ~sel_r[1];
   assign flash_select_two = ~sel_r[2];
   assign flash_addr = off_r[23:0];
   // extended lines carry only block bits, never general purpose
   assign flash_ext_addr_a = off_r[24] & linear_mode;
   assign flash_ext_addr_b = off_r[25] & linear_mode;
   assign flash_ext_addr_c = off_r[26] & linear_mode;
   assign flash_oe_n = ~(bus_act & ~we_r);
   assign flash_we_n = ~(bus_act & we_r);
   assign flash_data_out = wd_r;
   assign flash_data_oe = bus_act & we_r & ~tst_r;
   // all outputs float in board test; scan outs stay driven
   assign flash_pins_oe = ~tst_r;
   assign scan_outs_oe = 1'b1;
endmodule

// ### tb/flash_space_asserts.sv
// concurrent checks on the flash space decoder ports
`timescale 1ns/1ps
module flash_space_asserts (
   // clock and reset
   input wire mclk,
   input wire resetn,
   // processor side
   input wire linear_mode,
   input wire [1:0] op_mode,
   input wire acc_req,
   input wire acc_write,
   input wire [31:0] acc_addr,
   input wire acc_ready,
   input wire acc_err_r,
   input wire seq_start,
   input wire boot_done_r,
   input wire preload_flash_r,
   // flash and test pins
   input wire [23:0] flash_addr,
   input wire flash_select_zero,
   input wire flash_select_boot,
   input wire flash_select_two,
   input wire flash_ext_addr_a,
   input wire flash_ext_addr_b,
   input wire flash_ext_addr_c,
   input wire flash_pins_oe,
   input wire in_circuit_tristate_enable,
   input wire scan_outs_oe
);
   wire tk = acc_req && acc_ready && !acc_write;
   wire [7:0] top = acc_addr[31:24];
   wire [23:0] low = acc_addr[23:0];
   wire [2:0] blk = acc_addr[26:24];
   wire [2:0] sel = {flash_select_two, flash_select_boot, flash_select_zero};
   wire [2:0] ext = {flash_ext_addr_c, flash_ext_addr_b, flash_ext_addr_a};
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   AST_ONE_SEL: assert property ($countones(~sel) <= 1)
      else $error("two selects low");
   AST_CS0_MAP: assert property (tk && !linear_mode && top == 8'hf9
      |=> sel == 3'b110 && flash_addr == $past(low)) else $error("f9 map");
   AST_BOOT_MAP: assert property (tk && !linear_mode && top == 8'hfa
      |=> sel == 3'b101) else $error("fa map");
   AST_UNMAP: assert property (tk && !linear_mode && top[7:3] != 5'h1f
      |=> acc_err_r && sel == 3'b111) else $error("unmapped");
   AST_EXT_OFF: assert property (!linear_mode |-> ext == 3'h0)
      else $error("ext lines");
   AST_LIN_EXT: assert property (tk && linear_mode && top[7:3] == 5'h0
      && blk >= 3'h3 |=> ext == $past(blk)) else $error("linear ext");
   AST_PRE: assert property (seq_start && boot_done_r && op_mode == 2'h2
      |=> preload_flash_r) else $error("preload");
   AST_TRI: assert property (in_circuit_tristate_enable [*5]
      |-> !flash_pins_oe && scan_outs_oe) else $error("tristate");
   cover property (tk && linear_mode);
   cover property (acc_err_r);
   cover property (preload_flash_r);
endmodule
bind flash_space_decoder flash_space_asserts chk (.mclk, .resetn,
   .linear_mode, .op_mode, .acc_req, .acc_write, .acc_addr, .acc_ready,
   .acc_err_r, .seq_start, .boot_done_r, .preload_flash_r, .flash_addr,
   .flash_select_zero, .flash_select_boot, .flash_select_two,
   .flash_ext_addr_a, .flash_ext_addr_b, .flash_ext_addr_c, .flash_pins_oe,
   .in_circuit_tristate_enable, .scan_outs_oe);

// ### tb/nor_flash_model.sv
// behavioural parallel nor flash sitting on the three selects
`timescale 1ns/1ps
module nor_flash_model (
   // which selects have a part fitted
   input wire [2:0] present,
   // flash bus
   input wire flash_select_zero,
   input wire flash_select_boot,
   input wire flash_select_two,
   input wire [23:0] flash_addr,
   input wire flash_oe_n,
   input wire flash_pins_oe,
   output wire [15:0] flash_data_in
);
   wire [2:0] hit;
   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   assign hit = ~{flash_select_two, flash_select_boot, flash_select_zero};
   // released bus floats to the pull-up level, which is also what an
   // empty select reads, so a stale word can never look like a part
   assign flash_data_in = ((hit & present) != 3'h0 && !flash_oe_n &&
      flash_pins_oe) ? {flash_addr[15:8] ^ 8'h5a, flash_addr[7:0]} :
      16'hffff;
endmodule

// ### tb/tb.sv
// self-checking bench for the flash space decoder
`timescale 1ns/1ps
module tb;
   reg mclk, resetn, linear_mode, acc_req, acc_write, seq_start;
   reg in_circuit_tristate_enable;
   reg [1:0] op_mode;
   reg [31:0] acc_addr;
   reg [2:0] present, g_sel, g_ext;
   reg g_err;
   reg [2:0] g_ctl;
   reg [15:0] g_wd;
   wire flash_we_n, flash_data_oe;
   wire [15:0] flash_data_out;
   reg [23:0] g_addr;
   wire acc_ready, acc_err_r, preload_flash_r, preload_video_r, boot_done_r;
   wire boot_fail_r, flash_select_zero, flash_select_boot, flash_select_two;
   wire flash_ext_addr_a, flash_ext_addr_b, flash_ext_addr_c, flash_oe_n;
   wire flash_pins_oe, scan_outs_oe;
   wire [15:0] acc_rdata_r, flash_data_in;
   wire [2:0] present_r;
   wire [23:0] flash_addr;
   integer n_mismatch = 0, total_checks = 0, cyc = 0, n, m;
   flash_space_decoder dut (.mclk, .resetn, .linear_mode, .op_mode, .acc_req,
      .acc_write, .acc_addr, .acc_wdata(16'h1234), .acc_ready, .acc_rdata_r,
      .acc_err_r, .seq_start, .preload_flash_r, .preload_video_r, .present_r,
      .boot_done_r, .boot_fail_r, .flash_addr, .flash_select_zero,
      .flash_select_boot, .flash_select_two, .flash_ext_addr_a,
      .flash_ext_addr_b, .flash_ext_addr_c, .flash_oe_n, .flash_we_n,
      .flash_data_in, .flash_data_out, .flash_data_oe, .flash_pins_oe,
      .in_circuit_tristate_enable, .scan_outs_oe);
   nor_flash_model fm (.present, .flash_select_zero, .flash_select_boot,
      .flash_select_two, .flash_addr, .flash_oe_n, .flash_pins_oe,
      .flash_data_in);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task end_of_test;
      begin
         if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
      begin
         total_checks = total_checks + 1;
         if (e !== g) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task wait_rdy;
      begin
         n = 0;
         while (acc_ready !== 1'b1 && n < 200) begin
            @(posedge mclk);
            #1;
            n = n + 1;
         end
      end
   endtask
   task acc(input [31:0] a, input w);
      begin
         wait_rdy;
         @(posedge mclk);
         acc_req <= 1'b1;
         acc_write <= w;
         acc_addr <= a;
         @(posedge mclk);
         acc_req <= 1'b0;
         // error pulse stands only in the cycle after the taking edge
         #1;
         g_err = acc_err_r;
         g_ctl = {flash_we_n, flash_oe_n, flash_data_oe};
         g_wd = flash_data_out;
         g_sel = {flash_select_two, flash_select_boot, flash_select_zero};
         g_ext = {flash_ext_addr_c, flash_ext_addr_b, flash_ext_addr_a};
         g_addr = flash_addr;
         wait_rdy;
      end
   endtask
   task rd(input [31:0] a, input [2:0] s, input [2:0] x);
      begin
         acc(a, 1'b0);
         chk("sel", s, g_sel);
         chk("ext", x, g_ext);
         chk("addr", a[23:0], g_addr);
         chk("ctl", 3'b100, g_ctl);
         chk("cycles", 26, n);
         chk("rdata", {a[15:8] ^ 8'h5a, a[7:0]}, acc_rdata_r);
      end
   endtask
   task ex(input [31:0] a, input w, input e, input [2:0] s);
      begin
         acc(a, w);
         chk("err", e, g_err);
         chk("sel", s, g_sel);
         chk("ctl", e ? 3'b110 : (w ? 3'b011 : 3'b100), g_ctl);
         chk("cycles", e ? 0 : 26, n);
         if (w && !e)
            chk("wdata", 16'h1234, g_wd);
      end
   endtask
   task do_reset(input [2:0] p);
      begin
         @(posedge mclk);
         resetn <= 1'b0;
         present <= p;
         repeat (3) @(posedge mclk);
         resetn <= 1'b1;
         n = 0;
         while (boot_done_r !== 1'b1 && boot_fail_r !== 1'b1 && n < 300) begin
            @(posedge mclk);
            #1;
            n = n + 1;
         end
      end
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_seq;
      for (m = 0; m < 4; m = m + 1) begin
         @(posedge mclk);
         op_mode <= m[1:0];
         seq_start <= 1'b1;
         @(posedge mclk);
         seq_start <= 1'b0;
         #1;
         chk("pre_fl", m == 2, preload_flash_r);
         chk("pre_vid", m == 1, preload_video_r);
      end
   endtask
   task t_tri;
      begin
         @(posedge mclk);
         in_circuit_tristate_enable <= 1'b1;
         repeat (6) @(posedge mclk);
         #1;
         chk("pins_oe", 0, flash_pins_oe);
         chk("scan_oe", 1, scan_outs_oe);
         @(posedge mclk);
         in_circuit_tristate_enable <= 1'b0;
         repeat (6) @(posedge mclk);
         #1;
         chk("pins_oe", 1, flash_pins_oe);
      end
   endtask
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         end_of_test;
      end
   end
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      {resetn, linear_mode, acc_req, acc_write, seq_start} = 5'h0;
      {in_circuit_tristate_enable, op_mode, acc_addr} = 35'h0;
      do_reset(3'b111);
      chk("done", 1, boot_done_r);
      chk("present", 7, present_r);
      rd(32'hf9240010, 3'b110, 3'h0);
      rd(32'hfa000020, 3'b101, 3'h0);
      rd(32'hf8fff00e, 3'b011, 3'h0);
      ex(32'h05000000, 1'b0, 1'b1, 3'b111);
      ex(32'hf9000100, 1'b1, 1'b1, 3'b111);
      ex(32'hf923fffe, 1'b1, 1'b1, 3'b111);
      ex(32'hf9020000, 1'b1, 1'b0, 3'b110);
      ex(32'hf9240000, 1'b1, 1'b0, 3'b110);
      @(posedge mclk);
      linear_mode <= 1'b1;
      rd(32'h05123456, 3'b110, 3'h5);
      rd(32'h07fffff0, 3'b110, 3'h7);
      rd(32'hf8000010, 3'b011, 3'h2);
      ex(32'h08000000, 1'b0, 1'b1, 3'b111);
      t_seq;
      t_tri;
      do_reset(3'b101);
      chk("fail", 1, boot_fail_r);
      chk("present", 5, present_r);
      chk("done", 0, boot_done_r);
      chk("ready", 0, acc_ready);
      end_of_test;
   end
endmodule
